// *** bench/smbus_host_model.sv ***
/* Host model: one register access at a time on the link port.
   Assumes the link clock runs free. */
`timescale 1ns/10ps
module smbus_host_model (
  input  wire logic                    link_clk_in,   // Link clock
  input  wire logic                    acc_ready_in,  // Port idle
  input  wire logic                    rd_valid_in,   // Answer
  input  wire logic [7:0]              rd_data_in,    // Answer data
  input  wire logic                    rd_ack_in,     // Answer ack
  output logic                         acc_valid_out, // Strobe
  output temp_sensor_pkg::acc_req_type acc_req_out    // Request
);
  initial acc_valid_out = 1'b0;
  initial acc_req_out = '0;
  task automatic xfer(input temp_sensor_pkg::acc_kind_type k,
                      input logic [7:0] c, d,
                      output logic [7:0] rd, output logic ack);
    int i;
    @(negedge link_clk_in);
    acc_valid_out = 1'b1;
    acc_req_out = '{k, c, d};
    for (i = 0; i < 20 && acc_ready_in !== 1'b1; i++) @(posedge link_clk_in);
    @(posedge link_clk_in);
    @(negedge link_clk_in);
    acc_valid_out = 1'b0;
    // Released request shows no stale value
    acc_req_out = temp_sensor_pkg::acc_req_type'(~acc_req_out);
    for (i = 0; i < 20 && rd_valid_in !== 1'b1; i++) @(posedge link_clk_in);
    if (i == 20) temp_sensor_control_status_tb_top.fail_count++;
    rd = rd_data_in;
    ack = rd_ack_in;
  endtask : xfer
endmodule : smbus_host_model

// *** bench/temp_sensor_control_status_tb_top.sv ***
/* Bench top: sensor core driven by the host model.
   Assumes shortened conversion and interval counts. */
`timescale 1ns/10ps
module temp_sensor_control_status_tb_top;
  logic clk_in = 1'b0, link_clk_in = 1'b0, rstn_in = 1'b0, a;
  logic acc_valid_in, acc_ready_out, rd_valid_out, rd_ack_out, adc_start_out;
  logic junction_sel_out, alert_pin_out, alert_pin_oe_out;
  logic first_overtemp_out, second_overtemp_out;
  logic [7:0] rd_data_out, v;
  logic [1:0] addr_sel_in = temp_sensor_pkg::SEL_FLOAT;
  temp_sensor_pkg::acc_req_type acc_req_in;
  temp_sensor_pkg::limits_type limits_in = 64'h46C946C955557F7F;
  temp_sensor_pkg::adc_result_type adc_in = 23'h0C8190;
  int fail_count = 0, n_compared = 0, cyc = 0, last = 0, gap = 0, starts, n;
  temp_sensor_ctrl #(.CONV_CYC(100), .INTERVAL_CYC(120)) uut (.clk_in,
    .rstn_in, .link_clk_in, .acc_valid_in, .acc_req_in, .acc_ready_out,
    .rd_valid_out, .rd_data_out, .rd_ack_out, .standby_pin_in(1'b0),
    .addr_sel_in, .limits_in, .limit_update_in(1'b0), .adc_in,
    .adc_start_out, .junction_sel_out, .alert_pin_out, .alert_pin_oe_out,
    .first_overtemp_out, .second_overtemp_out);
  smbus_host_model host (.link_clk_in, .acc_ready_in(acc_ready_out),
    .rd_valid_in(rd_valid_out), .rd_data_in(rd_data_out),
    .rd_ack_in(rd_ack_out), .acc_valid_out(acc_valid_in),
    .acc_req_out(acc_req_in));
  initial forever #2 clk_in = ~clk_in;
  initial begin
    #1.3;
    forever #6 link_clk_in = ~link_clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (adc_start_out === 1'b1) begin
      gap = cyc - last;
      last = cyc;
      starts++;
    end
  end
  task automatic chk(input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] c);
    host.xfer(temp_sensor_pkg::ACC_POINTER, c, 8'h00, v, a);
    host.xfer(temp_sensor_pkg::ACC_READ, 8'h00, 8'h00, v, a);
  endtask : rd
  task automatic wr(input logic [7:0] c, d);
    host.xfer(temp_sensor_pkg::ACC_WRITE, c, d, v, a);
  endtask : wr
  // Set local temperature, then let conversions run
  task automatic setl(input logic [7:0] t);
    @(negedge clk_in);
    adc_in.local_temp = t;
    repeat (600) @(negedge clk_in);
  endtask : setl
  task final_report;
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (12) @(negedge clk_in);
    rstn_in = 1'b1;
    rd(temp_sensor_pkg::CMD_SETUP_RD); chk(v, 8'h20);
    rd(temp_sensor_pkg::CMD_RATE_RD); chk(v, 8'h08);
    rd(temp_sensor_pkg::CMD_FLAGS_RD); chk(v & 8'h7F, 8'h00);
    setl(8'h19); chk(8'(gap), 8'h78);
    wr(temp_sensor_pkg::CMD_RATE_WR, 8'hF7);
    setl(8'h19); setl(8'h19); chk(8'(gap), 8'hF0);
    wr(temp_sensor_pkg::CMD_SETUP_WR, 8'hFF);
    rd(temp_sensor_pkg::CMD_SETUP_RD); chk(v, 8'hE0);
    setl(8'h19); n = starts;
    host.xfer(temp_sensor_pkg::ACC_POINTER, 8'h0F, 8'h00, v, a);
    wr(temp_sensor_pkg::CMD_ONE_SHOT, 8'h00);
    setl(8'h19); chk(8'(starts - n), 8'h01);
    wr(temp_sensor_pkg::CMD_SETUP_WR, 8'h00);
    setl(8'h46); chk({7'h00, alert_pin_out}, 8'h01);
    chk({7'h00, junction_sel_out}, 8'h00);
    host.xfer(temp_sensor_pkg::ACC_ALERT_READ, 8'h00, 8'h00, v, a);
    chk(v, 8'h9B);
    chk({7'h00, a}, 8'h01);
    host.xfer(temp_sensor_pkg::ACC_ALERT_END, 8'h00, 8'h00, v, a);
    chk({7'h00, alert_pin_out}, 8'h01);
    setl(8'h19);
    rd(temp_sensor_pkg::CMD_FLAGS_RD); chk(v & 8'h7F, 8'h40);
    rd(temp_sensor_pkg::CMD_FLAGS_RD); chk(v & 8'h7F, 8'h00);
    chk({7'h00, alert_pin_out}, 8'h00);
    setl(8'h5A);
    rd(temp_sensor_pkg::CMD_FLAGS_RD);
    rd(temp_sensor_pkg::CMD_FLAGS_RD); chk(v & 8'h03, 8'h01);
    setl(8'h50); chk({7'h00, first_overtemp_out}, 8'h01);
    chk({7'h00, second_overtemp_out}, 8'h00);
    setl(8'h46); chk({7'h00, first_overtemp_out}, 8'h00);
    final_report;
  end
endmodule : temp_sensor_control_status_tb_top

// *** bench/temp_sensor_ctrl_assertions.sv ***
/* Port checker of the sensor core.
   Assumes binding onto temp_sensor_ctrl. */
`timescale 1ns/10ps
module temp_sensor_ctrl_checker (
  input wire logic       clk_in,          // Core clock
  input wire logic       rstn_in,         // Reset
  input wire logic       link_clk_in,     // Link clock
  input wire logic       acc_valid_in,    // Strobe
  input wire logic       acc_ready_out,   // Idle
  input wire logic       rd_valid_out,    // Answer
  input wire logic [7:0] rd_data_out,     // Data
  input wire logic       adc_start_out,   // Start
  input wire logic       alert_pin_out,   // Alarm
  input wire logic       alert_pin_oe_out // Low drives
);
  // ==========================================================================
  // Link port
  ready_drop_a: assert property (
    @(posedge link_clk_in) disable iff (!rstn_in)
    acc_valid_in && acc_ready_out |=> !acc_ready_out) else $error("no drop");
  answer_due_a: assert property (
    @(posedge link_clk_in) disable iff (!rstn_in)
    acc_valid_in && acc_ready_out |-> ##[2:12] rd_valid_out) else $error("late");
  ready_back_a: assert property (
    @(posedge link_clk_in) disable iff (!rstn_in)
    rd_valid_out |-> acc_ready_out) else $error("not idle");
  answer_pulse_a: assert property (
    @(posedge link_clk_in) disable iff (!rstn_in)
    rd_valid_out |=> !rd_valid_out) else $error("long answer");
  data_hold_a: assert property (
    @(posedge link_clk_in) disable iff (!rstn_in)
    !rd_valid_out |-> $stable(rd_data_out)) else $error("data moved");
  drop_cause_a: assert property (
    @(posedge link_clk_in) disable iff (!rstn_in)
    $fell(acc_ready_out) |-> $past(acc_valid_in)) else $error("stray drop");
  // ==========================================================================
  // Core
  start_space_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    adc_start_out |=> !adc_start_out [*8]) else $error("close starts");
  alert_drive_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    alert_pin_oe_out == !alert_pin_out) else $error("enable wrong");
endmodule : temp_sensor_ctrl_checker

bind temp_sensor_ctrl temp_sensor_ctrl_checker chk (.clk_in, .rstn_in,
  .link_clk_in, .acc_valid_in, .acc_ready_out, .rd_valid_out, .rd_data_out,
  .adc_start_out, .alert_pin_out, .alert_pin_oe_out);

// *** hw/temp_sensor_ctrl.sv ***
/*
  Control and status core of a two-channel temperature sensor: command
  pointer, setup, rate and hysteresis registers, flag byte, alarm latch,
  overtemperature outputs, conversion scheduling and address latch.
  Assumes a framing layer on the link clock that hands over one access
  at a time, and an analog front end on the core clock whose result
  inputs are valid when a conversion time has passed since the start.
*/
`timescale 1ns/10ps
module temp_sensor_ctrl #(
  parameter int         CONV_CYC     = temp_sensor_pkg::CONV_CYCLES,
  parameter int         INTERVAL_CYC = temp_sensor_pkg::INTERVAL_16HZ_CYC,
  parameter bit         THREE_ADDR   = 1'b1,
  parameter logic [7:0] DEVICE_ID    = 8'h5A  // Arbitrary value
) (
  input  wire logic                           clk_in,        // Core clock
  input  wire logic                           rstn_in,       // Async reset
  input  wire logic                           link_clk_in,   // Link clock
  input  wire logic                           acc_valid_in,  // Access strobe
  input  wire temp_sensor_pkg::acc_req_type   acc_req_in,    // Access
  output logic                                acc_ready_out, // Can take
  output logic                                rd_valid_out,  // Answer pulse
  output logic [7:0]                          rd_data_out,   // Answer data
  output logic                                rd_ack_out,    // Answer acked
  input  wire logic                           standby_pin_in, // Standby pin
  input  wire logic [1:0]                     addr_sel_in,   // Address pin
  input  wire temp_sensor_pkg::limits_type    limits_in,     // Thresholds
  input  wire logic                           limit_update_in, // Limit write
  input  wire temp_sensor_pkg::adc_result_type adc_in,       // Front end
  output logic                                adc_start_out, // Start pulse
  output logic                                junction_sel_out, // Junction
  output logic                                alert_pin_out, // Alarm level
  output logic                                alert_pin_oe_out, // Low=drive
  output logic                                first_overtemp_out,  // Ovt 1
  output logic                                second_overtemp_out  // Ovt 2
);

  if (CONV_CYC < 1 || INTERVAL_CYC < 1 ||
      INTERVAL_CYC > 16_777_215) begin : g_bad_counts
    $error("temp_sensor_ctrl: cycle counts out of range");
  end

  localparam logic [31:0] CONV_LAST = 32'(CONV_CYC - 1);
  localparam logic [31:0] BASE_CYC  = 32'(INTERVAL_CYC);

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] interval_of(input logic [3:0] code);
    logic [3:0] c;
    c = (code > temp_sensor_pkg::RATE_FASTEST) ?
        temp_sensor_pkg::RATE_FASTEST : code;
    return BASE_CYC << (temp_sensor_pkg::RATE_FASTEST - c);
  endfunction : interval_of

  function automatic logic ge_signed(input logic [7:0] a, input logic [7:0] b);
    return $signed(a) >= $signed(b);
  endfunction : ge_signed

  function automatic logic below_band(input logic [7:0] t,
                                      input logic [7:0] thr,
                                      input logic [7:0] overtemp_hysteresis);
    logic signed [9:0] band;
    band = $signed({{2{thr[7]}}, thr}) - $signed({2'h0, overtemp_hysteresis});
    return $signed({{2{t[7]}}, t}) < band;
  endfunction : below_band

  // Overtemperature with hysteresis; a limit rewrite re-evaluates plainly
  function automatic logic ovt_next(input logic cur, input logic [7:0] t,
                                    input logic [7:0] thr,
                                    input logic [7:0] overtemp_hysteresis,
                                    input logic reval);
    logic r;
    r = cur;
    if (ge_signed(t, thr)) begin
      r = 1'b1;
    end else if (reval || below_band(t, thr, overtemp_hysteresis)) begin
      r = 1'b0;
    end
    return r;
  endfunction : ovt_next

  // ==========================================================================
  // Link domain state
  typedef struct packed {
    temp_sensor_pkg::acc_req_type req;
    logic       req_tog;
    logic       ready;
    logic [2:0] rsp_sync;
    logic       rsp_seen;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       rd_ack;
  } link_state_type;

  // ==========================================================================
  // Core domain state
  typedef struct packed {
    logic [2:0]     setup;
    logic [7:0]     rate;
    logic [7:0]     overtemp_hysteresis;
    logic [7:0]     ptr;
    logic [4:0]     flags;
    logic [4:0]     cond;
    logic           alert;
    logic           ovt1_remote;
    logic           ovt1_local;
    logic           ovt2_remote;
    logic           ovt2_local;
    logic           busy;
    logic [31:0]    conv_cnt;
    logic [31:0]    rate_cnt;
    logic           auto_due;
    temp_sensor_pkg::adc_result_type res;
    logic           adc_start;
    logic [2:0]     req_sync;
    logic           req_seen;
    logic           rsp_tog;
    logic [7:0]     rsp_data;
    logic           rsp_ack;
    logic [2:0]     standby_pin_sync;
    logic [5:0]     sel_sync;
    logic [2:0]     settle;
    logic           addr_done;
    logic [6:0]     addr;
  } core_state_type;

  link_state_type lnk_ff;
  link_state_type nxt_lnk;
  core_state_type core_ff;
  core_state_type nxt_core;

  localparam link_state_type LINK_RESET = '{
    req: '{kind: temp_sensor_pkg::ACC_POINTER, cmd: 8'h00, data: 8'h00},
    req_tog: 1'b0, ready: 1'b1, rsp_sync: 3'h0, rsp_seen: 1'b0,
    rd_valid: 1'b0, rd_data: 8'h00, rd_ack: 1'b0
  };

  // ==========================================================================
  // Link side: hold one access, toggle across, wait for the answer toggle
  always_comb begin
    nxt_lnk          = lnk_ff;
    nxt_lnk.rd_valid = 1'b0;
    nxt_lnk.rsp_sync = {lnk_ff.rsp_sync[1:0], core_ff.rsp_tog};
    if (acc_valid_in && lnk_ff.ready) begin
      nxt_lnk.req     = acc_req_in;
      nxt_lnk.req_tog = ~lnk_ff.req_tog;
      nxt_lnk.ready   = 1'b0;
    end
    if (lnk_ff.rsp_sync[1] == lnk_ff.rsp_sync[2] &&
        lnk_ff.rsp_sync[2] != lnk_ff.rsp_seen) begin
      nxt_lnk.rsp_seen = lnk_ff.rsp_sync[2];
      nxt_lnk.rd_valid = 1'b1;
      nxt_lnk.rd_data  = core_ff.rsp_data;  // Stable until next answer
      nxt_lnk.rd_ack   = core_ff.rsp_ack;
      nxt_lnk.ready    = 1'b1;
    end
  end

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lnk_ff <= LINK_RESET;
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  // ==========================================================================
  // Core side
  logic        req_evt;
  logic        standby;
  logic        ext_ok;
  logic        conv_end;
  logic [4:0]  new_cond;
  logic [31:0] interval;
  logic [1:0]  sel_now;
  temp_sensor_pkg::acc_req_type req;

  assign req      = lnk_ff.req;  // Held stable while the toggle is in flight
  assign req_evt  = core_ff.req_sync[1] == core_ff.req_sync[2] &&
                    core_ff.req_sync[2] != core_ff.req_seen;
  assign standby  = core_ff.setup[temp_sensor_pkg::SETUP_STANDBY_PIN_BIT - 5] ||
                    (core_ff.standby_pin_sync[1] && core_ff.standby_pin_sync[2]);
  assign ext_ok   = core_ff.rate[3:0] <=
                    temp_sensor_pkg::RATE_EXT_SLOWEST_FAST;
  assign conv_end = core_ff.busy && core_ff.conv_cnt == CONV_LAST;
  assign interval = interval_of(core_ff.rate[3:0]);
  assign sel_now  = core_ff.sel_sync[5:4];

  // Alarm conditions from the front end at the end of a conversion
  assign new_cond = {
    ge_signed(adc_in.local_temp, limits_in.local_high),
    ge_signed(limits_in.local_low, adc_in.local_temp),
    ge_signed(adc_in.remote_temp, limits_in.remote_high),
    ge_signed(limits_in.remote_low, adc_in.remote_temp),
    adc_in.remote_open
  };

  always_comb begin
    logic       start;
    logic       one_shot;
    logic       flags_rd;
    logic       reval;
    logic [7:0] rd;
    start    = 1'b0;
    one_shot = 1'b0;
    flags_rd = 1'b0;
    reval    = limit_update_in;
    rd       = 8'h00;
    nxt_core           = core_ff;
    nxt_core.adc_start = 1'b0;
    nxt_core.req_sync  = {core_ff.req_sync[1:0], lnk_ff.req_tog};
    nxt_core.standby_pin_sync = {core_ff.standby_pin_sync[1:0], standby_pin_in};
    nxt_core.sel_sync  = {core_ff.sel_sync[3:0], addr_sel_in};

    // Address pin taken once, after the synchroniser has settled
    if (!core_ff.addr_done) begin
      if (core_ff.sel_sync[3:2] == core_ff.sel_sync[5:4] &&
          core_ff.settle == 3'(temp_sensor_pkg::ADDR_SETTLE_CYC)) begin
        nxt_core.addr_done = 1'b1;
        if (THREE_ADDR && sel_now == temp_sensor_pkg::SEL_VCC) begin
          nxt_core.addr = temp_sensor_pkg::ADDR_VCC;
        end else if (THREE_ADDR && sel_now == temp_sensor_pkg::SEL_FLOAT) begin
          nxt_core.addr = temp_sensor_pkg::ADDR_FLOAT;
        end else begin
          nxt_core.addr = temp_sensor_pkg::ADDR_GND;
        end
      end else begin
        nxt_core.settle = core_ff.settle + 3'h1;
      end
    end

    // One access at a time, completed in a single core cycle
    if (req_evt) begin
      nxt_core.req_seen = core_ff.req_sync[2];
      nxt_core.rsp_tog  = ~core_ff.rsp_tog;
      nxt_core.rsp_ack  = 1'b1;
      unique case (req.kind)
        temp_sensor_pkg::ACC_POINTER,
        temp_sensor_pkg::ACC_WRITE: begin
          nxt_core.ptr = req.cmd;
          if (req.cmd == temp_sensor_pkg::CMD_ONE_SHOT) begin
            one_shot = 1'b1;
          end
          if (req.kind == temp_sensor_pkg::ACC_WRITE) begin
            unique case (req.cmd)
              temp_sensor_pkg::CMD_SETUP_WR: begin
                nxt_core.setup = req.data[7:5];
              end
              temp_sensor_pkg::CMD_RATE_WR: begin
                nxt_core.rate = req.data;
              end
              temp_sensor_pkg::CMD_OVERTEMP_HYSTERESIS: begin
                nxt_core.overtemp_hysteresis = req.data;
                reval         = 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
        temp_sensor_pkg::ACC_READ: begin
          unique case (core_ff.ptr)
            temp_sensor_pkg::CMD_LOCAL_TEMP:  rd = core_ff.res.local_temp;
            temp_sensor_pkg::CMD_REMOTE_TEMP: rd = core_ff.res.remote_temp;
            temp_sensor_pkg::CMD_FLAGS_RD: begin
              flags_rd = 1'b1;
              rd = {core_ff.busy, core_ff.flags,
                    core_ff.ovt1_remote, core_ff.ovt1_local};
            end
            temp_sensor_pkg::CMD_SETUP_RD: rd = {core_ff.setup, 5'h00};
            temp_sensor_pkg::CMD_RATE_RD:  rd = core_ff.rate;
            temp_sensor_pkg::CMD_REMOTE_EXT: begin
              rd = ext_ok ? {core_ff.res.remote_frac, 5'h00} : 8'h00;
            end
            temp_sensor_pkg::CMD_LOCAL_EXT: begin
              rd = ext_ok ? {core_ff.res.local_frac, 5'h00} : 8'h00;
            end
            temp_sensor_pkg::CMD_OVERTEMP_HYSTERESIS: rd = core_ff.overtemp_hysteresis;
            temp_sensor_pkg::CMD_ID:   rd = DEVICE_ID;
            default:                   rd = 8'h00;
          endcase
        end
        temp_sensor_pkg::ACC_ALERT_READ: begin
          rd               = {core_ff.addr, 1'b1};
          nxt_core.rsp_ack = alert_pin_out;
        end
        temp_sensor_pkg::ACC_ALERT_END: begin
          if (req.data[0]) begin
            nxt_core.alert = 1'b0;
          end
        end
        default: begin
          nxt_core.rsp_ack = 1'b0;
        end
      endcase
      nxt_core.rsp_data = rd;
    end

    // Flag clear on read keeps persisting conditions
    if (flags_rd) begin
      nxt_core.flags = core_ff.flags & core_ff.cond;
      nxt_core.alert = 1'b0;
    end

    // Conversion scheduling
    if (!standby) begin
      if (core_ff.rate_cnt >= interval - 32'h1) begin
        nxt_core.auto_due = 1'b1;
      end else begin
        nxt_core.rate_cnt = core_ff.rate_cnt + 32'h1;
      end
    end else begin
      nxt_core.rate_cnt = 32'h0;
      nxt_core.auto_due = 1'b0;
    end
    if (core_ff.busy) begin
      nxt_core.conv_cnt = core_ff.conv_cnt + 32'h1;
    end else if (one_shot) begin
      start = 1'b1;
    end else if (core_ff.auto_due && !standby) begin
      start = 1'b1;
    end
    if (start) begin
      nxt_core.busy      = 1'b1;
      nxt_core.conv_cnt  = 32'h0;
      nxt_core.rate_cnt  = 32'h1;
      nxt_core.auto_due  = 1'b0;
      nxt_core.adc_start = 1'b1;
    end
    // Start cycle counts as the first of the interval
    // One-shot during a conversion falls through untouched

    // End of conversion: snapshot results, latch conditions; set wins
    if (conv_end) begin
      nxt_core.busy  = 1'b0;
      nxt_core.res   = adc_in;
      nxt_core.cond  = new_cond;
      nxt_core.flags = nxt_core.flags | new_cond;
      if (|new_cond) begin
        nxt_core.alert = 1'b1;
      end
    end

    // Overtemperature outputs track the snapshot, never cleared by reads
    nxt_core.ovt1_local  = ovt_next(core_ff.ovt1_local,
                                    core_ff.res.local_temp,
                                    limits_in.local_ovt1, core_ff.overtemp_hysteresis,
                                    reval);
    nxt_core.ovt1_remote = ovt_next(core_ff.ovt1_remote,
                                    core_ff.res.remote_temp,
                                    limits_in.remote_ovt1, core_ff.overtemp_hysteresis,
                                    reval);
    nxt_core.ovt2_local  = ovt_next(core_ff.ovt2_local,
                                    core_ff.res.local_temp,
                                    limits_in.local_ovt2, core_ff.overtemp_hysteresis,
                                    reval);
    nxt_core.ovt2_remote = ovt_next(core_ff.ovt2_remote,
                                    core_ff.res.remote_temp,
                                    limits_in.remote_ovt2, core_ff.overtemp_hysteresis,
                                    reval);
  end

  localparam core_state_type CORE_RESET = '{
    setup: temp_sensor_pkg::SETUP_RESET, rate: temp_sensor_pkg::RATE_RESET,
    overtemp_hysteresis: temp_sensor_pkg::OVERTEMP_HYSTERESIS_RESET, ptr: temp_sensor_pkg::PTR_RESET,
    flags: 5'h00, cond: 5'h00, alert: 1'b0,
    ovt1_remote: 1'b0, ovt1_local: 1'b0, ovt2_remote: 1'b0, ovt2_local: 1'b0,
    busy: 1'b1, conv_cnt: 32'h0, rate_cnt: 32'h0, auto_due: 1'b0,
    res: '0, adc_start: 1'b1, req_sync: 3'h0, req_seen: 1'b0,
    rsp_tog: 1'b0, rsp_data: 8'h00, rsp_ack: 1'b0, standby_pin_sync: 3'h0,
    sel_sync: 6'h00, settle: 3'h0, addr_done: 1'b0,
    addr: temp_sensor_pkg::ADDR_GND
  };

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_ff <= CORE_RESET;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // ==========================================================================
  // Outputs
  logic alert_q;
  logic alert_oe_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      alert_q    <= 1'b0;
      alert_oe_q <= 1'b1;
    end else begin
      alert_q    <= nxt_core.alert &&
                    !nxt_core.setup[temp_sensor_pkg::SETUP_MASK_BIT - 5];
      alert_oe_q <= !(nxt_core.alert &&
                    !nxt_core.setup[temp_sensor_pkg::SETUP_MASK_BIT - 5]);
    end
  end

  assign alert_pin_out       = alert_q;
  assign alert_pin_oe_out    = alert_oe_q;
  assign acc_ready_out       = lnk_ff.ready;
  assign rd_valid_out        = lnk_ff.rd_valid;
  assign rd_data_out         = lnk_ff.rd_data;
  assign rd_ack_out          = lnk_ff.rd_ack;
  assign adc_start_out       = core_ff.adc_start;
  assign junction_sel_out    =
    core_ff.setup[temp_sensor_pkg::SETUP_JUNC_BIT - 5];
  assign first_overtemp_out  = core_ff.ovt1_local | core_ff.ovt1_remote;
  assign second_overtemp_out = core_ff.ovt2_local | core_ff.ovt2_remote;

endmodule : temp_sensor_ctrl

// *** hw/temp_sensor_pkg.sv ***
/*
  Constants, field layouts and carrier types of the temperature sensor
  control and status block.
  Assumes a 4 ns core clock and an outside framing layer that turns bus
  traffic into single register accesses.
*/
// Behaviour
// - One-shot in standby runs one full conversion, then stays in standby.
// - One-shot arriving during a conversion is ignored.
// - One-shot between auto conversions starts one and restarts rate timer.
// - Setup bit 7, reset 0, suppresses the alarm output when 1.
// - Setup bit 6, reset 0: 1 standby, 0 autonomous conversion.
// - Setup bit 5, reset 1, selects substrate PNP or discrete junction.
// - Setup bits 4 to 0 always read back as zero.
// - Flag bit 7 is high while converting; it is 1 after power-on.
// - Flag bits 6 to 3 latch local/remote high/low trips, reset 0.
// - Flag bit 2 latches remote junction open circuit, reset 0.
// - Flag read clears bits 6 to 2 unless their condition persists.
// - Alarm output follows latched flags, clears on read, reasserts later.
// - Bits 1 and 0 show overtemperature; a read never clears them.
// - Overtemperature ends below threshold minus hysteresis, or on rewrite.
// - Flag byte carries nothing of the second overtemperature output.
// - Bus accesses and conversions run asynchronously without corruption.
// - Rate codes 0 to 8 double from 0.0625 Hz; 9 is 16 Hz.
// - Only the low four rate bits are decoded; reset value 08h.
// - Fractional results only at 4 Hz or slower.
// - Results valid one conversion time after any start.
// - Slave address fixed or pin selected, sampled once after power-on.
// - Alert response read returns address in bits 7..1, 1 in bit 0.
// - Alarm condition when a temperature equals or exceeds its high limit.
// - Lost alert response arbitration keeps the alarm output asserted.
// - Power-up: autoconvert 16 Hz, alarm clear, pointer 0, overtemp_hysteresis 10.
package temp_sensor_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS      = 4;
  localparam int CONV_TIME_NS       = 125_000_000;
  localparam int CONV_CYCLES        = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int INTERVAL_16HZ_NS   = 62_500_000;
  localparam int INTERVAL_16HZ_CYC  = INTERVAL_16HZ_NS / CLK_PERIOD_NS;
  localparam int ADDR_SETTLE_CYC    = 4;

  // ==========================================================================
  // Command pointer codes
  localparam logic [7:0] CMD_LOCAL_TEMP  = 8'h00;
  localparam logic [7:0] CMD_REMOTE_TEMP = 8'h01;
  localparam logic [7:0] CMD_FLAGS_RD    = 8'h02;
  localparam logic [7:0] CMD_SETUP_RD    = 8'h03;
  localparam logic [7:0] CMD_RATE_RD     = 8'h04;
  localparam logic [7:0] CMD_SETUP_WR    = 8'h09;
  localparam logic [7:0] CMD_RATE_WR     = 8'h0A;
  localparam logic [7:0] CMD_ONE_SHOT    = 8'h0F;
  localparam logic [7:0] CMD_REMOTE_EXT  = 8'h10;
  localparam logic [7:0] CMD_LOCAL_EXT   = 8'h11;
  localparam logic [7:0] CMD_OVERTEMP_HYSTERESIS        = 8'h21;
  localparam logic [7:0] CMD_ID          = 8'hFE;

  // ==========================================================================
  // Field positions and reset values
  localparam int         SETUP_MASK_BIT  = 7;
  localparam int         SETUP_STANDBY_PIN_BIT  = 6;
  localparam int         SETUP_JUNC_BIT  = 5;
  localparam logic [2:0] SETUP_RESET     = 3'h1;
  localparam logic [7:0] RATE_RESET      = 8'h08;
  localparam logic [3:0] RATE_FASTEST    = 4'h8;
  localparam logic [3:0] RATE_EXT_SLOWEST_FAST = 4'h6;
  localparam logic [7:0] OVERTEMP_HYSTERESIS_RESET      = 8'h0A;
  localparam logic [7:0] PTR_RESET       = 8'h00;
  localparam logic [6:0] ADDR_GND        = 7'h4C;
  localparam logic [6:0] ADDR_VCC        = 7'h4E;
  localparam logic [6:0] ADDR_FLOAT      = 7'h4D;
  localparam logic [1:0] SEL_VCC         = 2'h1;
  localparam logic [1:0] SEL_FLOAT       = 2'h2;

  // ==========================================================================
  // Carrier types
  typedef enum logic [2:0] {
    ACC_POINTER, ACC_WRITE, ACC_READ, ACC_ALERT_READ, ACC_ALERT_END
  } acc_kind_type;

  typedef struct packed {
    acc_kind_type kind;
    logic [7:0]   cmd;
    logic [7:0]   data;
  } acc_req_type;

  typedef struct packed {
    logic [7:0] local_high;
    logic [7:0] local_low;
    logic [7:0] remote_high;
    logic [7:0] remote_low;
    logic [7:0] local_ovt1;
    logic [7:0] remote_ovt1;
    logic [7:0] local_ovt2;
    logic [7:0] remote_ovt2;
  } limits_type;

  typedef struct packed {
    logic [7:0] local_temp;
    logic [2:0] local_frac;
    logic [7:0] remote_temp;
    logic [2:0] remote_frac;
    logic       remote_open;
  } adc_result_type;

endpackage : temp_sensor_pkg
